//--- core/cpu_addressing.sv
// Program counter, two-word handling and data memory addressing of the core
module cpu_addressing
    import addr_pkg::*;
#(
    parameter logic [15:0] BANK_MASK = 16'hffff
)
(
    input  wire logic               clk_sys_in,
    input  wire logic               nrst_in,
    input  wire logic [WORD_W-1:0]  instr_word_in,
    input  wire cmd_t               cmd_in,
    input  wire logic [7:0]         wr_data_in,
    input  wire logic [7:0]         ram_rdata_in,
    input  wire logic               usb_enable_in,
    input  wire usb_req_t           usb_req_in,
    output logic      [PC_W-1:0]    prog_addr_out,
    output logic      [WORD_W-1:0]  ir_out,
    output logic                    ir_valid_out,
    output logic                    exec_nop_out,
    output logic      [11:0]        literal_out,
    output logic                    literal_valid_out,
    output logic      [7:0]         operand_out,
    output logic      [7:0]         bank_selector_out,
    output logic      [PC_W-1:0]    pc_out,
    output quarter_t                quarter_out,
    output ram_port_t               ram_out,
    output logic                    usb_grant_out,
    output logic                    usb_done_out,
    output logic      [7:0]         usb_rdata_out
);

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic is_tag_word(input logic [WORD_W-1:0] w);
        is_tag_word = (w[15:12] == TWO_WORD_TAG);
    endfunction

    function automatic logic opens_two_word(input cmd_kind_t k);
        opens_two_word = (k == CMD_JUMP) || (k == CMD_MOVE) || (k == CMD_TWO_WORD);
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    quarter_t           q_r,           q_nxt;
    logic [PC_W-1:0]    pc_r,          pc_nxt;
    logic [PC_W-1:0]    fetch_addr_r,  fetch_addr_nxt;
    logic [WORD_W-1:0]  ir_r,          ir_nxt;
    logic               ir_valid_r,    ir_valid_nxt;
    logic               exec_nop_r,    exec_nop_nxt;
    logic               lit_valid_r,   lit_valid_nxt;
    logic [7:0]         bank_r,        bank_nxt;
    logic               pend_r,        pend_nxt;
    cmd_kind_t          pend_kind_r,   pend_kind_nxt;
    logic [7:0]         pend_lo_r,     pend_lo_nxt;
    logic [7:0]         operand_r,     operand_nxt;
    rd_src_t            rd_src_r,      rd_src_nxt;
    logic               wr_pcl_r,      wr_pcl_nxt;
    logic               wr_bank_r,     wr_bank_nxt;
    ram_port_t          ram_r,         ram_nxt;
    logic               usb_slot_r,    usb_slot_nxt;
    logic               usb_done_r,    usb_done_nxt;
    logic [7:0]         usb_rdata_r,   usb_rdata_nxt;

    logic               exec_act;
    logic               first_exec;
    logic               second_exec;
    logic               use_full;
    logic [DADDR_W-1:0] map_addr;
    logic               map_impl;
    logic [PC_W-1:0]    branch_step;
    logic               pc_loaded;

    // ========================================================================
    // Data address forming
    // ========================================================================
    assign exec_act    = ir_valid_r && !exec_nop_r;
    assign first_exec  = exec_act && !pend_r;
    assign second_exec = exec_act && pend_r && lit_valid_r;
    // Move source from the first word, destination from the second word
    assign use_full    = (first_exec && (cmd_in.kind == CMD_MOVE))
                      || (second_exec && (pend_kind_r == CMD_MOVE));

    data_addr_map #(
        .BANK_MASK       (BANK_MASK)
    ) u_map (
        .bank_in         (bank_r),
        .operand_in      (ir_r[7:0]),
        .access_in       (cmd_in.access),
        .use_full_in     (use_full),
        .full_addr_in    (ir_r[11:0]),
        .addr_out        (map_addr),
        .implemented_out (map_impl)
    );

    // Offset counts words, so it is sign extended and doubled
    assign branch_step = PC_W'({{(PC_W-OFFS_W){cmd_in.offset[OFFS_W-1]}},
                                cmd_in.offset} << 1);

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        q_nxt          = quarter_t'(q_r + 2'b01);
        pc_nxt         = pc_r;
        fetch_addr_nxt = fetch_addr_r;
        ir_nxt         = ir_r;
        ir_valid_nxt   = ir_valid_r;
        exec_nop_nxt   = exec_nop_r;
        lit_valid_nxt  = lit_valid_r;
        bank_nxt       = bank_r;
        pend_nxt       = pend_r;
        pend_kind_nxt  = pend_kind_r;
        pend_lo_nxt    = pend_lo_r;
        operand_nxt    = operand_r;
        rd_src_nxt     = rd_src_r;
        wr_pcl_nxt     = 1'b0;
        wr_bank_nxt    = 1'b0;
        ram_nxt        = '0;
        usb_slot_nxt   = 1'b0;
        usb_done_nxt   = 1'b0;
        usb_rdata_nxt  = usb_rdata_r;
        pc_loaded      = 1'b0;

        // USB takes the free first and third quarters, only while enabled
        if (((q_r == QTR_4) || (q_r == QTR_2)) && usb_enable_in && usb_req_in.req)
        begin
            ram_nxt.re    = !usb_req_in.we;
            ram_nxt.we    = usb_req_in.we;
            ram_nxt.addr  = usb_req_in.addr;
            ram_nxt.wdata = usb_req_in.wdata;
            usb_slot_nxt  = 1'b1;
        end
        if (usb_slot_r)
        begin
            usb_rdata_nxt = ram_rdata_in;
            usb_done_nxt  = 1'b1;
        end

        case (q_r)
            QTR_1:
            begin
                fetch_addr_nxt = pc_r;
                pc_nxt         = pc_r + PC_STEP;
                // Set up the operand read for the second quarter
                if (first_exec && ((cmd_in.kind == CMD_FILE) || (cmd_in.kind == CMD_MOVE)))
                begin
                    if (!map_impl)
                    begin
                        rd_src_nxt = RD_ZERO;
                    end
                    else if (map_addr == BANK_SEL_ADDR)
                    begin
                        rd_src_nxt = RD_BANK;
                    end
                    else if (map_addr == PCL_ADDR)
                    begin
                        rd_src_nxt = RD_PCL;
                    end
                    else
                    begin
                        rd_src_nxt  = RD_RAM;
                        ram_nxt.re  = 1'b1;
                        ram_nxt.addr = map_addr;
                    end
                end
                else
                begin
                    rd_src_nxt = RD_ZERO;
                end
            end
            QTR_2:
            begin
                case (rd_src_r)
                    RD_RAM:  operand_nxt = ram_rdata_in;
                    RD_BANK: operand_nxt = bank_r & BANK_SEL_MASK;
                    RD_PCL:  operand_nxt = pc_r[7:0];
                    default: operand_nxt = (second_exec && (pend_kind_r == CMD_MOVE))
                                         ? operand_r : 8'h00;
                endcase
            end
            QTR_3:
            begin
                // Set up the destination write for the fourth quarter
                if ((first_exec && (cmd_in.kind == CMD_FILE) && cmd_in.write_en)
                    || (second_exec && (pend_kind_r == CMD_MOVE)))
                begin
                    if (map_addr == PCL_ADDR)
                    begin
                        wr_pcl_nxt = 1'b1;
                    end
                    else if (map_addr == BANK_SEL_ADDR)
                    begin
                        wr_bank_nxt = 1'b1;
                    end
                    else if (map_impl)
                    begin
                        ram_nxt.we    = 1'b1;
                        ram_nxt.addr  = map_addr;
                        ram_nxt.wdata = use_full ? operand_r : wr_data_in;
                    end
                end
                if (wr_pcl_nxt || wr_bank_nxt)
                begin
                    ram_nxt.wdata = use_full ? operand_r : wr_data_in;
                end
            end
            default:
            begin
                // Fourth quarter: execute side effects and latch the fetch
                if (wr_pcl_r)
                begin
                    pc_nxt[7:0] = ram_r.wdata & PCL_ALIGN_MASK;
                    pc_loaded   = 1'b1;
                end
                if (wr_bank_r)
                begin
                    bank_nxt = ram_r.wdata & BANK_SEL_MASK;
                end
                if (first_exec && (cmd_in.kind == CMD_BANK_LOAD))
                begin
                    bank_nxt = ir_r[7:0] & BANK_SEL_MASK;
                end
                if (first_exec && (cmd_in.kind == CMD_BRANCH))
                begin
                    pc_nxt    = fetch_addr_r + branch_step;
                    pc_loaded = 1'b1;
                end
                if (second_exec && (pend_kind_r == CMD_JUMP))
                begin
                    pc_nxt    = {ir_r[11:0], pend_lo_r, 1'b0};
                    pc_loaded = 1'b1;
                end
                if (first_exec && opens_two_word(cmd_in.kind))
                begin
                    pend_nxt      = 1'b1;
                    pend_kind_nxt = cmd_in.kind;
                    pend_lo_nxt   = ir_r[7:0];
                end
                else
                begin
                    pend_nxt = 1'b0;
                end
                // Word fetched behind a program counter load is flushed
                ir_nxt        = instr_word_in;
                ir_valid_nxt  = !pc_loaded;
                exec_nop_nxt  = is_tag_word(instr_word_in) && !pend_nxt;
                lit_valid_nxt = is_tag_word(instr_word_in) && pend_nxt;
            end
        endcase
        pc_nxt[0] = 1'b0;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            q_r          <= QTR_1;
            pc_r         <= PC_RESET;
            fetch_addr_r <= PC_RESET;
            ir_r         <= '0;
            ir_valid_r   <= 1'b0;
            exec_nop_r   <= 1'b0;
            lit_valid_r  <= 1'b0;
            bank_r       <= BANK_SEL_RESET;
            pend_r       <= 1'b0;
            pend_kind_r  <= CMD_NONE;
            pend_lo_r    <= 8'h00;
            operand_r    <= 8'h00;
            rd_src_r     <= RD_ZERO;
            wr_pcl_r     <= 1'b0;
            wr_bank_r    <= 1'b0;
            ram_r        <= '0;
            usb_slot_r   <= 1'b0;
            usb_done_r   <= 1'b0;
            usb_rdata_r  <= 8'h00;
        end
        else
        begin
            q_r          <= q_nxt;
            pc_r         <= pc_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            ir_r         <= ir_nxt;
            ir_valid_r   <= ir_valid_nxt;
            exec_nop_r   <= exec_nop_nxt;
            lit_valid_r  <= lit_valid_nxt;
            bank_r       <= bank_nxt;
            pend_r       <= pend_nxt;
            pend_kind_r  <= pend_kind_nxt;
            pend_lo_r    <= pend_lo_nxt;
            operand_r    <= operand_nxt;
            rd_src_r     <= rd_src_nxt;
            wr_pcl_r     <= wr_pcl_nxt;
            wr_bank_r    <= wr_bank_nxt;
            ram_r        <= ram_nxt;
            usb_slot_r   <= usb_slot_nxt;
            usb_done_r   <= usb_done_nxt;
            usb_rdata_r  <= usb_rdata_nxt;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign prog_addr_out     = fetch_addr_r;
    assign ir_out            = ir_r;
    assign ir_valid_out      = ir_valid_r;
    assign exec_nop_out      = exec_nop_r;
    assign literal_out       = ir_r[11:0];
    assign literal_valid_out = lit_valid_r;
    assign operand_out       = operand_r;
    assign bank_selector_out = bank_r;
    assign pc_out            = pc_r;
    assign quarter_out       = q_r;
    assign ram_out           = ram_r;
    assign usb_grant_out     = usb_slot_r;
    assign usb_done_out      = usb_done_r;
    assign usb_rdata_out     = usb_rdata_r;

endmodule

//--- core/addr_pkg.sv
// Shared constants and types for the core memory addressing block
// Notes on behaviour
// - Program memory is byte addressed; instruction words start on even addresses.
// - Program counter steps by two per word; its bit zero always reads zero.
// - Absolute jump loads its word address into program counter bits 20 to 1.
// - Relative branch offset counts single words, so it is doubled before adding.
// - Second word of a two-word instruction has 1111 on top, 12 literal bits.
// - A 1111 word reached alone is a no-operation; after its first word it is data.
// - Data addresses are 12 bits: sixteen banks of 256 bytes, 4096 bytes in all.
// - Reads of unimplemented data locations return zero.
// - A 256-byte access window reaches low bank zero and top registers without banking.
// - With USB off the RAM is plain storage; with USB on it is shared with USB.
// - Banked address is bank selector on top and the 8-bit operand below.
// - Only bank selector bits 3 to 0 exist; upper bits read zero, ignore writes.
// - Bank literal load writes its literal straight into the bank selector.
// - Writes to unimplemented banks vanish, except to FE0h and FF9h; reads give zero.
// - Full address move uses two 12-bit addresses and ignores the bank selector.
// - Addresses F40h to F5Fh are outside the window; reach them through banking.
// - Banked write to F9h in bank 0Fh lands in the program counter low byte.
// - Window maps 00h-5Fh to bank 0 start and 60h-FFh to bank 15 top.
// - Access bit one uses bank selector plus operand; zero uses the window.
// - Operand is read in the second quarter, destination written in the fourth.
package addr_pkg;

    // ========================================================================
    // Widths and values
    // ========================================================================
    localparam int          PC_W           = 21;
    localparam int          DADDR_W        = 12;
    localparam int          BANK_W         = 4;
    localparam int          WORD_W         = 16;
    localparam int          OFFS_W         = 11;
    localparam logic [20:0] PC_RESET       = 21'h000000;
    localparam logic [20:0] PC_STEP        = 21'h000002;
    localparam logic [7:0]  BANK_SEL_RESET = 8'h00;
    localparam logic [7:0]  BANK_SEL_MASK  = 8'h0f;
    localparam logic [3:0]  TWO_WORD_TAG   = 4'hf;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
    localparam logic [11:0] PCL_ADDR       = 12'hff9;
    localparam logic [11:0] BANK_SEL_ADDR  = 12'hfe0;
    localparam logic [3:0]  USB_BUF_BANK   = 4'h4;
    localparam logic [7:0]  PCL_ALIGN_MASK = 8'hfe;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0]
    {
        QTR_1 = 2'b00,
        QTR_2 = 2'b01,
        QTR_3 = 2'b10,
        QTR_4 = 2'b11
    } quarter_t;

    typedef enum logic [2:0]
    {
        CMD_NONE      = 3'b000,
        CMD_FILE      = 3'b001,
        CMD_JUMP      = 3'b010,
        CMD_BRANCH    = 3'b011,
        CMD_BANK_LOAD = 3'b100,
        CMD_MOVE      = 3'b101,
        CMD_TWO_WORD  = 3'b110
    } cmd_kind_t;

    typedef enum logic [1:0]
    {
        RD_RAM  = 2'b00,
        RD_ZERO = 2'b01,
        RD_BANK = 2'b10,
        RD_PCL  = 2'b11
    } rd_src_t;

    typedef struct packed
    {
        cmd_kind_t          kind;
        logic               access;
        logic               write_en;
        logic [OFFS_W-1:0]  offset;
    } cmd_t;

    typedef struct packed
    {
        logic               req;
        logic               we;
        logic [DADDR_W-1:0] addr;
        logic [7:0]         wdata;
    } usb_req_t;

    typedef struct packed
    {
        logic               re;
        logic               we;
        logic [DADDR_W-1:0] addr;
        logic [7:0]         wdata;
    } ram_port_t;

endpackage

//--- core/data_addr_map.sv
// Data address former: banked, access window and full address paths
module data_addr_map
    import addr_pkg::*;
#(
    parameter logic [15:0] BANK_MASK = 16'hffff
)
(
    input  wire logic [7:0]         bank_in,
    input  wire logic [7:0]         operand_in,
    input  wire logic               access_in,
    input  wire logic               use_full_in,
    input  wire logic [DADDR_W-1:0] full_addr_in,
    output logic      [DADDR_W-1:0] addr_out,
    output logic                    implemented_out
);

    always_comb
    begin
        if (use_full_in)
        begin
            addr_out = full_addr_in;
        end
        else if (access_in)
        begin
            addr_out = {bank_in[BANK_W-1:0], operand_in};
        end
        else if (operand_in < ACCESS_SPLIT)
        begin
            addr_out = {ACCESS_LO_BANK, operand_in};
        end
        else
        begin
            // Top window starts at F60h, so F40h-F5Fh is never reached here
            addr_out = {ACCESS_HI_BANK, operand_in};
        end
        implemented_out = BANK_MASK[addr_out[DADDR_W-1:8]];
    end

endmodule

//--- tb/cpu_addressing_assertions.sv
// Concurrent checks on the ports of the core addressing block
module cpu_addressing_assertions
    import addr_pkg::*;
#(
    parameter logic [15:0] BANK_MASK = 16'hffff
)
(
    input wire logic              clk_sys_in,
    input wire logic              nrst_in,
    input wire cmd_t              cmd_in,
    input wire logic              usb_enable_in,
    input wire logic [PC_W-1:0]   pc_out,
    input wire logic [WORD_W-1:0] ir_out,
    input wire logic              ir_valid_out,
    input wire logic              exec_nop_out,
    input wire logic [11:0]       literal_out,
    input wire logic              literal_valid_out,
    input wire logic [7:0]        bank_selector_out,
    input wire quarter_t          quarter_out,
    input wire ram_port_t         ram_out,
    input wire logic              usb_grant_out,
    input wire logic              usb_done_out
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    logic own, rd2;
    // Decoder commands only count for a live first word
    assign own = ir_valid_out && !literal_valid_out && !exec_nop_out;
    assign rd2 = ram_out.re && quarter_out == QTR_2 && own;
    // ========
    // Program side
    AST_PC_EVEN: assert property (pc_out[0] == 1'b0)
        else $error("odd program counter");
    AST_QTR_SEQ: assert property (quarter_out == QTR_1 |=> quarter_out == QTR_2 ##1
        quarter_out == QTR_3 ##1 quarter_out == QTR_4 ##1 quarter_out == QTR_1)
        else $error("quarter order broken");
    AST_LITERAL: assert property (literal_valid_out |-> ir_out[15:12] == TWO_WORD_TAG
        && literal_out == ir_out[11:0]) else $error("bad literal");
    AST_NOP: assert property (exec_nop_out |-> ir_out[15:12] == TWO_WORD_TAG
        && !(ram_out.we && !usb_grant_out)) else $error("orphan word wrote data");
    // ========
    // Data side
    AST_CORE_WR: assert property (ram_out.we && !usb_grant_out |-> quarter_out == QTR_4)
        else $error("core write outside fourth quarter");
    AST_BANK_UPPER: assert property (bank_selector_out[7:4] == 4'h0)
        else $error("bank selector upper bits set");
    AST_BANK_LOAD: assert property (own && cmd_in.kind == CMD_BANK_LOAD
        && quarter_out == QTR_4 |=> bank_selector_out == {4'h0, $past(ir_out[3:0])})
        else $error("bank load lost");
    AST_BANKED: assert property (rd2 && cmd_in.kind == CMD_FILE && cmd_in.access
        |-> ram_out.addr == {bank_selector_out[3:0], ir_out[7:0]}) else $error("bad bank address");
    AST_WINDOW: assert property (rd2 && cmd_in.kind == CMD_FILE && !cmd_in.access
        |-> ram_out.addr == {(ir_out[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK,
        ir_out[7:0]}) else $error("bad window address");
    AST_MOVE_SRC: assert property (rd2 && cmd_in.kind == CMD_MOVE
        |-> ram_out.addr == ir_out[11:0]) else $error("bad move source");
    AST_UNIMPL: assert property (ram_out.we && !usb_grant_out
        |-> BANK_MASK[ram_out.addr[11:8]]) else $error("write to absent bank");
    AST_USB_DONE: assert property (usb_grant_out |=> usb_done_out && !usb_grant_out)
        else $error("usb done late");
    AST_USB_OFF: assert property (!usb_enable_in && !$past(usb_enable_in)
        |-> !usb_grant_out) else $error("usb granted while off");
    cover property (exec_nop_out);
    cover property (literal_valid_out);
    cover property (usb_done_out);
endmodule

//--- tb/cpu_mem_model.sv
// Program memory, banked data RAM and decoder facing the addressing block
module cpu_mem_model
    import addr_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic [PC_W-1:0]   prog_addr_in,
    input  wire logic [WORD_W-1:0] ir_in,
    input  wire logic [7:0]        operand_in,
    input  wire ram_port_t         ram_in,
    output logic      [WORD_W-1:0] instr_word_out,
    output cmd_t                   cmd_out,
    output logic      [7:0]        wr_data_out,
    output logic      [7:0]        ram_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prog [64];
    logic [7:0]  mem [4096];
    logic [7:0]  cyc = 8'h00;
    // ========
    // Contents
    initial
    begin
        prog = '{0: 16'h1003, 1: 16'h6110, 2: 16'h6020, 3: 16'h6070, 4: 16'hf123,
            5: 16'hc050, 6: 16'hf2a0, 7: 16'he00a, 8: 16'hf000, 9: 16'h6021, 10: 16'hd002,
            11: 16'h6022, 12: 16'h6023, 13: 16'h6024, 14: 16'h10fe, 15: 16'h6130, 16: 16'h1001,
            17: 16'h6105, 18: 16'h100f, 19: 16'h63f9, 20: 16'h6026, 32: 16'h6025, 33: 16'he021,
            34: 16'hf000, default: 16'h0000};
        // Bank 4 and F40h-F5Fh stay untouched by the program
        mem = '{12'h310: 8'h41, 12'h020: 8'h07, 12'hf70: 8'h10, 12'h050: 8'h5a,
            12'h105: 8'h33, default: 8'h00};
    end
    // ========
    // Fetch, decode and RAM port
    assign instr_word_out = prog[prog_addr_in[6:1]];
    always_comb
    begin
        cmd_out.access   = ir_in[8];
        cmd_out.write_en = ir_in[15:12] == 4'h6;
        cmd_out.offset   = ir_in[10:0];
        case (ir_in[15:12])
            4'h1:    cmd_out.kind = CMD_BANK_LOAD;
            4'h6:    cmd_out.kind = CMD_FILE;
            4'hc:    cmd_out.kind = CMD_MOVE;
            4'hd:    cmd_out.kind = CMD_BRANCH;
            4'he:    cmd_out.kind = CMD_JUMP;
            default: cmd_out.kind = CMD_NONE;
        endcase
        // Bit 9 gives a fixed result so a program counter write lands somewhere known
        wr_data_out = (ir_in[15:12] == 4'h1) ? ir_in[7:0] : ir_in[9] ? 8'h41 : operand_in + 8'h01;
    end
    // Read data is not held outside a read strobe
    assign ram_rdata_out = ram_in.re ? mem[ram_in.addr] : cyc;
    always @(posedge clk_sys_in)
    begin
        cyc <= cyc + 8'h01;
        if (ram_in.we)
            mem[ram_in.addr] <= ram_in.wdata;
    end
endmodule

//--- tb/tb_cpu_addressing.sv
// Self-checking bench for the core addressing block
module tb_cpu_addressing
    import addr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BANK_MASK = 16'hfffd;
    logic              clk_sys_in = 1'b0;
    logic              nrst_in, usb_enable_in, ir_valid_out, exec_nop_out, literal_valid_out;
    logic              usb_grant_out, usb_done_out, seen_grant, nop_seen = 1'b0;
    logic [7:0]        wr_data_in, ram_rdata_in, operand_out, bank_selector_out, usb_rdata_out, rd;
    logic [11:0]       literal_out;
    logic [WORD_W-1:0] instr_word_in, ir_out;
    logic [PC_W-1:0]   prog_addr_out, pc_out;
    usb_req_t          usb_req_in;
    cmd_t              cmd_in;
    quarter_t          quarter_out;
    ram_port_t         ram_out;
    int                n_mismatch = 0;
    int                total_checks = 0;
    // Address and expected byte once the program has parked
    logic [19:0]       exp_tab [12] = '{20'h31042, 20'h02008, 20'hf7011, 20'h2a05a, 20'h02100,
        20'h02200, 20'h02300, 20'h02401, 20'he3001, 20'h10533, 20'h02600, 20'h02501};
    cpu_addressing #(.BANK_MASK(BANK_MASK)) u_dut
    (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .instr_word_in(instr_word_in),
        .cmd_in(cmd_in), .wr_data_in(wr_data_in), .ram_rdata_in(ram_rdata_in),
        .usb_enable_in(usb_enable_in), .usb_req_in(usb_req_in), .prog_addr_out(prog_addr_out),
        .ir_out(ir_out), .ir_valid_out(ir_valid_out), .exec_nop_out(exec_nop_out),
        .literal_out(literal_out), .literal_valid_out(literal_valid_out),
        .operand_out(operand_out), .bank_selector_out(bank_selector_out), .pc_out(pc_out),
        .quarter_out(quarter_out), .ram_out(ram_out), .usb_grant_out(usb_grant_out),
        .usb_done_out(usb_done_out), .usb_rdata_out(usb_rdata_out)
    );
    cpu_mem_model u_mem
    (
        .clk_sys_in(clk_sys_in), .prog_addr_in(prog_addr_out), .ir_in(ir_out),
        .operand_in(operand_out), .ram_in(ram_out), .instr_word_out(instr_word_in),
        .cmd_out(cmd_in), .wr_data_out(wr_data_in), .ram_rdata_out(ram_rdata_in)
    );
    always #2 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in)
        if (exec_nop_out === 1'b1)
            nop_seen <= 1'b1;
    // ========
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic usb_xfer(input logic we, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n = 0;
        @(posedge clk_sys_in);
        #1;
        usb_req_in = '{1'b1, we, a, d};
        while (usb_done_out !== 1'b1 && n < 16)
        begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        q = usb_rdata_out;
        usb_req_in.req = 1'b0;
        check(n < 16, 1'b1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========
    // Tests
    initial
    begin
        nrst_in = 1'b0;
        usb_enable_in = 1'b1;
        usb_req_in = '0;
        repeat (20) @(posedge clk_sys_in);
        #1;
        check(bank_selector_out, 8'h00);
        nrst_in = 1'b1;
        repeat (400) @(posedge clk_sys_in);
        #1;
        check(nop_seen, 1'b1);
        check(bank_selector_out, 8'h0f);
        $display("program run done");
        foreach (exp_tab[i])
        begin
            usb_xfer(1'b0, exp_tab[i][19:8], 8'h00, rd);
            check(rd, exp_tab[i][7:0]);
        end
        $display("data memory test done");
        usb_xfer(1'b1, 12'h480, 8'h9c, rd);
        usb_xfer(1'b0, 12'h480, 8'h00, rd);
        check(rd, 8'h9c);
        usb_enable_in = 1'b0;
        usb_req_in = '{1'b1, 1'b1, 12'h481, 8'h77};
        seen_grant = 1'b0;
        repeat (12)
        begin
            @(posedge clk_sys_in);
            #1;
            seen_grant = seen_grant | usb_grant_out;
        end
        usb_req_in.req = 1'b0;
        usb_enable_in = 1'b1;
        check(seen_grant, 1'b0);
        usb_xfer(1'b0, 12'h481, 8'h00, rd);
        check(rd, 8'h00);
        $display("usb test done");
        end_of_test();
    end
    // Tests need about 490 cycles; this leaves a wide margin
    initial
    begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule

bind cpu_addressing cpu_addressing_assertions #(.BANK_MASK(BANK_MASK)) u_chk
(
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cmd_in(cmd_in), .usb_enable_in(usb_enable_in),
    .pc_out(pc_out), .ir_out(ir_out), .ir_valid_out(ir_valid_out), .exec_nop_out(exec_nop_out),
    .literal_out(literal_out), .literal_valid_out(literal_valid_out),
    .bank_selector_out(bank_selector_out), .quarter_out(quarter_out), .ram_out(ram_out),
    .usb_grant_out(usb_grant_out), .usb_done_out(usb_done_out)
);
